// ### rpc_pkg.sv
// package: register map, field positions and reset values for the regulator control block
package rpc_pkg;
   localparam int         ADDR_W           = 16;
   // byte addresses of the two registers
   localparam logic [15:0] PMGT_OFFSET     = 16'h1930;
   localparam logic [15:0] REG_CTRL_OFFSET = 16'h7004;
   // power management register fields
   localparam int         CLKOUT_BIT       = 0;
   localparam int         REG_PD_BIT       = 1;
   localparam int         BANDGAP_PD_BIT   = 2;
   localparam int         WAKE_DIR_BIT     = 3;
   localparam int         WAKE_OUT_BIT     = 4;
   localparam logic [4:0] PMGT_RESET       = 5'h10;
   // regulator control register fields
   localparam int         USB_EN_BIT       = 0;
   localparam int         VSEL_BIT         = 1;
   localparam logic       VSEL_RESET       = 1'b0;
   // axi responses
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage

// ### rpc_wake_pin.sv
// wake pin: open-drain output path and input wake qualifier
module rpc_wake_pin (
   input  wire logic direction,
   input  wire logic out_value,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      wake_request
);
   always_comb begin
      pin_out      = 1'b0;
      pin_oe       = direction & ~out_value;
      wake_request = ~direction & pin_in;
   end
endmodule

// ### rpc_axi_slave.sv
// axi4-lite slave front end: accepts one write and one read, gives strobes to the core
module rpc_axi_slave #(
   parameter int ADDR_W = rpc_pkg::ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   wr_strobe,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [31:0]            wr_data,
   output logic [3:0]             wr_strb,
   input  wire logic              wr_hit,
   output logic [ADDR_W-1:0]      rd_addr,
   input  wire logic [31:0]       rd_value,
   input  wire logic              rd_hit
);
   logic              aw_have_reg, aw_have_next;
   logic              w_have_reg, w_have_next;
   logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic [31:0]       w_data_reg, w_data_next;
   logic [3:0]        w_strb_reg, w_strb_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   logic              rvalid_reg, rvalid_next;
   logic [1:0]        rresp_reg, rresp_next;
   logic [31:0]       rdata_reg, rdata_next;

   always_comb begin
      awready      = ce & ~aw_have_reg & ~bvalid_reg;
      wready       = ce & ~w_have_reg & ~bvalid_reg;
      arready      = ce & ~rvalid_reg;
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      wr_strobe    = 1'b0;
      if (awvalid && awready) begin
         aw_have_next = 1'b1;
         aw_addr_next = awaddr;
      end
      if (wvalid && wready) begin
         w_have_next = 1'b1;
         w_data_next = wdata;
         w_strb_next = wstrb;
      end
      if (ce && aw_have_reg && w_have_reg) begin
         wr_strobe    = 1'b1;
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = wr_hit ? rpc_pkg::RESP_OKAY : rpc_pkg::RESP_SLVERR;
      end
      if (ce && bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (arvalid && arready) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_value;
         rresp_next  = rd_hit ? rpc_pkg::RESP_OKAY : rpc_pkg::RESP_SLVERR;
      end
      if (ce && rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= rpc_pkg::RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= rpc_pkg::RESP_OKAY;
         rdata_reg   <= '0;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg  <= w_have_next;
         aw_addr_reg <= aw_addr_next;
         w_data_reg  <= w_data_next;
         w_strb_reg  <= w_strb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   always_comb begin
      bvalid  = bvalid_reg;
      bresp   = bresp_reg;
      rvalid  = rvalid_reg;
      rresp   = rresp_reg;
      rdata   = rdata_reg;
      wr_addr = aw_addr_reg;
      wr_data = w_data_reg;
      wr_strb = w_strb_reg;
      rd_addr = araddr;
   end
endmodule

// ### rpc_regulator_ctrl.sv
// top: regulator power-down, strap and wake control with axi4-lite registers
// Behaviour
// - either power-down bit disables all three regulators
// - bandgap bit also stops reset circuit, bandgap
// - regulator bit stops regulators, reset circuit; bandgap on
// - wake pin high or alarm re-enables
// - analog regulator on unless powered down
// - core regulator off while disable strap high
// - disabled core/usb regulator output floats
// - voltage select writable, reset gives 1.3 V
// - strap high at reset: usb off, software controls
// - strap low at reset: usb forced on
// - wake out value 0 drives pin low
// - wake direction: 0 input, 1 open-drain output
// - pin wakeup only when direction is input
// - clock output follows enable bit
// - power register bits 15:5 read zero
// - voltage select 0 is 1.3 V, 1 is 1.05 V
// - usb enable bit switches usb output
module rpc_regulator_ctrl #(
   parameter int ADDR_W = rpc_pkg::ADDR_W
) (
   input  wire logic              REF_CLK,
   input  wire logic              RST,
   input  wire logic              CE,
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   input  wire logic              CORE_REGULATOR_DISABLE_STRAP,
   input  wire logic              CLOCK_SOURCE_STRAP,
   input  wire logic              RTC_ALARM,
   input  wire logic              RTC_CLOCK,
   input  wire logic              WAKE_PIN_IN,
   output logic                   WAKE_PIN_OUT,
   output logic                   WAKE_PIN_OE,
   output logic                   ANALOG_REGULATOR_ON,
   output logic                   CORE_REGULATOR_ON,
   output logic                   CORE_REGULATOR_OUTPUT_PIN_OE,
   output logic                   CORE_REGULATOR_VOLTAGE_SELECT,
   output logic                   USB_REGULATOR_ON,
   output logic                   USB_REGULATOR_OUTPUT_PIN_OE,
   output logic                   ANALOG_POR_ON,
   output logic                   BANDGAP_ON,
   output logic                   RTC_CLOCK_OUT
);
   logic [4:0]        pmgt_reg, pmgt_next;
   logic              vsel_reg, vsel_next;
   logic              usb_en_reg, usb_en_next;
   logic              usb_lock_reg, usb_lock_next;
   logic              strap_taken_reg, strap_taken_next;
   logic              wr_strobe;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              wr_hit;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0]       rd_value;
   logic              rd_hit;
   logic              pin_wake;
   logic              wake_event;
   logic              powered_down;
   logic              wr_pmgt;
   logic              wr_ldo;

   rpc_axi_slave #(
      .ADDR_W (ADDR_W)
   ) u_bus (
      .clk       (REF_CLK),
      .rst       (RST),
      .ce        (CE),
      .awaddr    (AWADDR),
      .awvalid   (AWVALID),
      .awready   (AWREADY),
      .wdata     (WDATA),
      .wstrb     (WSTRB),
      .wvalid    (WVALID),
      .wready    (WREADY),
      .bresp     (BRESP),
      .bvalid    (BVALID),
      .bready    (BREADY),
      .araddr    (ARADDR),
      .arvalid   (ARVALID),
      .arready   (ARREADY),
      .rdata     (RDATA),
      .rresp     (RRESP),
      .rvalid    (RVALID),
      .rready    (RREADY),
      .wr_strobe (wr_strobe),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_hit    (wr_hit),
      .rd_addr   (rd_addr),
      .rd_value  (rd_value),
      .rd_hit    (rd_hit)
   );

   rpc_wake_pin u_wake (
      .direction    (pmgt_reg[rpc_pkg::WAKE_DIR_BIT]),
      .out_value    (pmgt_reg[rpc_pkg::WAKE_OUT_BIT]),
      .pin_in       (WAKE_PIN_IN),
      .pin_out      (WAKE_PIN_OUT),
      .pin_oe       (WAKE_PIN_OE),
      .wake_request (pin_wake)
   );

   // address decode
   always_comb begin
      wr_hit   = (wr_addr == rpc_pkg::PMGT_OFFSET) || (wr_addr == rpc_pkg::REG_CTRL_OFFSET);
      wr_pmgt  = wr_strobe && (wr_addr == rpc_pkg::PMGT_OFFSET) && wr_strb[0];
      wr_ldo   = wr_strobe && (wr_addr == rpc_pkg::REG_CTRL_OFFSET) && wr_strb[0];
      rd_hit   = 1'b1;
      rd_value = '0;
      if (rd_addr == rpc_pkg::PMGT_OFFSET) begin
         rd_value[4:0] = pmgt_reg;
      end else if (rd_addr == rpc_pkg::REG_CTRL_OFFSET) begin
         rd_value[rpc_pkg::USB_EN_BIT] = usb_en_reg;
         rd_value[rpc_pkg::VSEL_BIT]   = vsel_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // power-down and wake state
   always_comb begin
      powered_down     = pmgt_reg[rpc_pkg::BANDGAP_PD_BIT] | pmgt_reg[rpc_pkg::REG_PD_BIT];
      wake_event       = pin_wake | RTC_ALARM;
      pmgt_next        = pmgt_reg;
      vsel_next        = vsel_reg;
      usb_en_next      = usb_en_reg;
      usb_lock_next    = usb_lock_reg;
      strap_taken_next = 1'b1;
      if (!strap_taken_reg) begin
         usb_lock_next = ~CLOCK_SOURCE_STRAP;
         usb_en_next   = ~CLOCK_SOURCE_STRAP;
      end
      if (wr_pmgt) begin
         pmgt_next = wr_data[4:0];
      end
      if (wr_ldo) begin
         vsel_next   = wr_data[rpc_pkg::VSEL_BIT];
         usb_en_next = wr_data[rpc_pkg::USB_EN_BIT] | usb_lock_reg;
      end
      if (powered_down && wake_event) begin
         pmgt_next[rpc_pkg::BANDGAP_PD_BIT] = 1'b0;
         pmgt_next[rpc_pkg::REG_PD_BIT]     = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pmgt_reg        <= rpc_pkg::PMGT_RESET;
         vsel_reg        <= rpc_pkg::VSEL_RESET;
         usb_en_reg      <= 1'b0;
         usb_lock_reg    <= 1'b0;
         strap_taken_reg <= 1'b0;
      end else if (CE) begin
         pmgt_reg        <= pmgt_next;
         vsel_reg        <= vsel_next;
         usb_en_reg      <= usb_en_next;
         usb_lock_reg    <= usb_lock_next;
         strap_taken_reg <= strap_taken_next;
      end
   end

   // regulator, reference and clock outputs
   always_comb begin
      ANALOG_REGULATOR_ON           = ~powered_down;
      CORE_REGULATOR_ON             = ~powered_down & ~CORE_REGULATOR_DISABLE_STRAP;
      CORE_REGULATOR_OUTPUT_PIN_OE  = CORE_REGULATOR_ON;
      CORE_REGULATOR_VOLTAGE_SELECT = vsel_reg;
      USB_REGULATOR_ON              = ~powered_down & usb_en_reg;
      USB_REGULATOR_OUTPUT_PIN_OE   = USB_REGULATOR_ON;
      ANALOG_POR_ON                 = ~powered_down;
      BANDGAP_ON                    = ~pmgt_reg[rpc_pkg::BANDGAP_PD_BIT];
      RTC_CLOCK_OUT                 = RTC_CLOCK & pmgt_reg[rpc_pkg::CLKOUT_BIT];
   end
endmodule

// ### rpc_board_model.sv
// board model: pulled-up wake line with an optional board driver
module rpc_board_model (
   input  wire logic drive_en,
   input  wire logic drive_val,
   input  wire logic pin_oe,
   input  wire logic pin_out,
   output logic      pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // device pulls low, else board drives, else pull-up
   assign pin_level = pin_oe ? pin_out : (drive_en ? drive_val : 1'b1);
endmodule

// ### rpc_regulator_ctrl_monitor.sv
// checker: port-level assertions for the regulator control block
module rpc_regulator_ctrl_monitor (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic CORE_REGULATOR_DISABLE_STRAP,
   input wire logic RTC_ALARM,
   input wire logic RTC_CLOCK,
   input wire logic WAKE_PIN_OUT,
   input wire logic WAKE_PIN_OE,
   input wire logic ANALOG_REGULATOR_ON,
   input wire logic CORE_REGULATOR_ON,
   input wire logic CORE_REGULATOR_OUTPUT_PIN_OE,
   input wire logic USB_REGULATOR_ON,
   input wire logic USB_REGULATOR_OUTPUT_PIN_OE,
   input wire logic ANALOG_POR_ON,
   input wire logic BANDGAP_ON,
   input wire logic RTC_CLOCK_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   a_pd_overrides_all: assert property (!ANALOG_REGULATOR_ON |-> !CORE_REGULATOR_ON && !USB_REGULATOR_ON)
      else $error("regulator on during power-down");
   a_bandgap_off_all: assert property (!BANDGAP_ON |-> !ANALOG_REGULATOR_ON && !ANALOG_POR_ON)
      else $error("circuit on with bandgap off");
   a_por_tracks_analog: assert property (ANALOG_POR_ON == ANALOG_REGULATOR_ON)
      else $error("reset circuit and analog regulator differ");
   a_alarm_restores: assert property (CE && RTC_ALARM && !ANALOG_REGULATOR_ON |-> ##1 ANALOG_REGULATOR_ON)
      else $error("alarm did not restore regulators");
   a_core_strap_off: assert property (CORE_REGULATOR_DISABLE_STRAP |-> !CORE_REGULATOR_ON)
      else $error("core regulator on with strap high");
   a_core_pin_float: assert property (CORE_REGULATOR_OUTPUT_PIN_OE == CORE_REGULATOR_ON)
      else $error("core output pin state wrong");
   a_usb_pin_float: assert property (USB_REGULATOR_OUTPUT_PIN_OE == USB_REGULATOR_ON)
      else $error("usb output pin state wrong");
   a_wake_drives_low: assert property (WAKE_PIN_OE |-> !WAKE_PIN_OUT)
      else $error("wake pin driven high");
   a_clkout_gated: assert property (RTC_CLOCK_OUT |-> RTC_CLOCK)
      else $error("clock output without clock");
endmodule

bind rpc_regulator_ctrl rpc_regulator_ctrl_monitor mon_u (.*);

// ### tb_top.sv
// testbench: register, strap, power-down and wake scenarios
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, q;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP, r;
   logic        REF_CLK, RST, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY, brd_en, brd_val;
   logic        CORE_REGULATOR_DISABLE_STRAP, CLOCK_SOURCE_STRAP, RTC_ALARM, RTC_CLOCK;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, WAKE_PIN_IN, WAKE_PIN_OUT, WAKE_PIN_OE;
   logic        ANALOG_REGULATOR_ON, CORE_REGULATOR_ON, CORE_REGULATOR_OUTPUT_PIN_OE;
   logic        USB_REGULATOR_ON, USB_REGULATOR_OUTPUT_PIN_OE, ANALOG_POR_ON, BANDGAP_ON;
   logic        CORE_REGULATOR_VOLTAGE_SELECT, RTC_CLOCK_OUT;
   int          fail_count = 0;
   int          n_compared = 0;
   wire  [6:0]  st = {ANALOG_REGULATOR_ON, ANALOG_POR_ON, BANDGAP_ON, CORE_REGULATOR_ON,
                       CORE_REGULATOR_OUTPUT_PIN_OE, USB_REGULATOR_ON, USB_REGULATOR_OUTPUT_PIN_OE};
   localparam logic [15:0] PM = rpc_pkg::PMGT_OFFSET;
   localparam logic [15:0] LC = rpc_pkg::REG_CTRL_OFFSET;

   rpc_regulator_ctrl dut_u (.*);
   rpc_board_model brd_u (.drive_en(brd_en), .drive_val(brd_val), .pin_oe(WAKE_PIN_OE),
                          .pin_out(WAKE_PIN_OUT), .pin_level(WAKE_PIN_IN));

   task automatic report_and_stop;
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] rs);
      int   n;
      logic ha, hw, hb;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge REF_CLK);
         ha = AWVALID && AWREADY;
         hw = WVALID && WREADY;
         hb = BVALID;
         rs = BRESP;
         @(posedge REF_CLK);
         if (ha) AWVALID <= 1'b0;
         if (hw) WVALID <= 1'b0;
         if (hb) break;
      end
      BREADY <= 1'b0;
      @(posedge REF_CLK);
      if (n == 40) begin
         fail_count++;
         report_and_stop();
      end
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] dq, output logic [1:0] rs);
      int   n;
      logic ha, hr;
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge REF_CLK);
         ha = ARVALID && ARREADY;
         hr = RVALID;
         dq = RDATA;
         rs = RRESP;
         @(posedge REF_CLK);
         if (ha) ARVALID <= 1'b0;
         if (hr) break;
      end
      RREADY <= 1'b0;
      @(posedge REF_CLK);
      if (n == 40) begin
         fail_count++;
         report_and_stop();
      end
   endtask

   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      rd(a, q, r);
      chk("rdata", q, e);
   endtask

   task automatic stc(input logic [6:0] e);
      @(negedge REF_CLK);
      chk("regulators", 32'(st), 32'(e));
      @(posedge REF_CLK);
   endtask

   task automatic rst_with(input logic s);
      CLOCK_SOURCE_STRAP <= s;
      RST <= 1'b1;
      repeat (12) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
   endtask

   initial begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end

   initial begin
      {CE, WSTRB, brd_en} <= 6'h3F;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, RTC_ALARM, RTC_CLOCK, brd_val} <= '0;
      {AWADDR, ARADDR, WDATA, CORE_REGULATOR_DISABLE_STRAP} <= '0;
      rst_with(1'b1);
      rc(PM, 32'h0000_0010);
      rc(LC, 32'h0000_0000);
      stc(7'h7C);
      wr(LC, 32'h0000_0003, r);
      rc(LC, 32'h0000_0003);
      chk("vsel", 32'(CORE_REGULATOR_VOLTAGE_SELECT), 32'h0000_0001);
      stc(7'h7F);
      wr(LC, 32'h0000_0000, r);
      stc(7'h7C);
      wr(PM, 32'hFFFF_FFF1, r);
      rc(PM, 32'h0000_0011);
      RTC_CLOCK <= 1'b1;
      stc(7'h7C);
      chk("clkout", 32'(RTC_CLOCK_OUT), 32'h0000_0001);
      wr(PM, 32'h0000_0008, r);
      chk("wake", 32'({WAKE_PIN_OE, WAKE_PIN_IN}), 32'h0000_0002);
      chk("clkout", 32'(RTC_CLOCK_OUT), 32'h0000_0000);
      wr(PM, 32'h0000_0018, r);
      brd_en <= 1'b0;
      stc(7'h7C);
      chk("wake", 32'({WAKE_PIN_OE, WAKE_PIN_IN}), 32'h0000_0001);
      // bandgap power-down, then the pulled-up wake pin set to input re-enables
      wr(PM, 32'h0000_001C, r);
      stc(7'h00);
      wr(PM, 32'h0000_0014, r);
      stc(7'h7C);
      rc(PM, 32'h0000_0010);
      brd_en <= 1'b1;
      wr(LC, 32'h0000_0001, r);
      wr(PM, 32'h0000_0012, r);
      stc(7'h10);
      RTC_ALARM <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      RTC_ALARM <= 1'b0;
      stc(7'h7F);
      rc(PM, 32'h0000_0010);
      wr(16'h0100, 32'h0000_0001, r);
      chk("bresp", 32'(r), 32'(rpc_pkg::RESP_SLVERR));
      rd(16'h0100, q, r);
      chk("rresp", 32'(r), 32'(rpc_pkg::RESP_SLVERR));
      CORE_REGULATOR_DISABLE_STRAP <= 1'b1;
      stc(7'h73);
      CORE_REGULATOR_DISABLE_STRAP <= 1'b0;
      rst_with(1'b0);
      rc(LC, 32'h0000_0001);
      wr(LC, 32'h0000_0000, r);
      rc(LC, 32'h0000_0001);
      stc(7'h7F);
      report_and_stop();
   end
endmodule
